// File: src/ebpwm_pkg.sv
package ebpwm_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_DUTYL = 8'h04;
    localparam logic [7:0] ADDR_DUTYH = 8'h08;
    localparam logic [7:0] ADDR_DEL   = 8'h0c;
    localparam logic [7:0] ADDR_PER   = 8'h10;
    localparam logic [7:0] ADDR_TCFG  = 8'h14;
    localparam logic [7:0] ADDR_STAT  = 8'h18;
    localparam logic [7:0] ADDR_TB    = 8'h1c;
    // Control register fields
    localparam int CFG_HI = 7;
    localparam int CFG_LO = 6;
    localparam int DLSB_HI = 5;
    localparam int DLSB_LO = 4;
    localparam int MODE_HI = 3;
    localparam int MODE_LO = 0;
    localparam logic [1:0] MODE_PWM_TOP = 2'h3;
    localparam logic [3:0] MODE_OFF     = 4'h0;
    localparam logic [3:0] MODE_SPECIAL = 4'hb;
    // Output configurations
    localparam logic [1:0] CFG_SINGLE = 2'h0;
    localparam logic [1:0] CFG_FWD    = 2'h1;
    localparam logic [1:0] CFG_HALF   = 2'h2;
    localparam logic [1:0] CFG_REV    = 2'h3;
    // Timer config bits
    localparam int TCFG_PS_HI = 1;
    localparam int TCFG_T2ON  = 2;
    localparam int TCFG_T1ON  = 3;
    // Status bits
    localparam int STAT_EVT  = 0;
    localparam int STAT_T1OV = 1;
    localparam int STAT_T2IF = 2;
    localparam int STAT_TMR_LO = 8;
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] DEL_RST  = 8'h00;
    localparam logic [7:0] PER_RST  = 8'hff;
    localparam logic [3:0] TCFG_RST = 4'h0;
    // Prescale limits, in clocks minus one
    localparam logic [3:0] PS1_LIM  = 4'h0;
    localparam logic [3:0] PS4_LIM  = 4'h3;
    localparam logic [3:0] PS16_LIM = 4'hf;
    // Timing: pclk is the oscillator clock
    localparam int CLK_NS   = 40;
    localparam int TOSC_NS  = 40;
    localparam int DB_TOSC  = 4;
    localparam int DB_CYC   = (DB_TOSC * TOSC_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [9:0] DBC_MAX = 10'h3ff;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } ebpwm_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } ebpwm_apb_rsp_t;

    typedef struct packed {
        ebpwm_apb_rsp_t rsp;
        logic [7:0]  ctrl;
        logic [7:0]  dutyl;
        logic [7:0]  dutyh;
        logic [7:0]  del;
        logic [7:0]  per;
        logic [3:0]  tcfg;
        logic        evt;
        logic        t1ov;
        logic        t2if;
        logic [1:0]  cfg_sh;
        logic [1:0]  pol_sh;
        logic [9:0]  duty_sh;
        logic [7:0]  del_wk;
        logic        run;
        logic [3:0]  ps_cnt;
        logic [1:0]  q;
        logic [7:0]  tmr;
        logic [15:0] tb;
        logic        raw;
        logic [9:0]  dbc;
        logic [3:0]  out;
        logic [3:0]  own_n;
        logic        trig;
        logic        adc_s1;
        logic        adc_s2;
    } ebpwm_state_t;
endpackage : ebpwm_pkg

// File: src/ebpwm_top.sv
`timescale 1ns/1ps
module ebpwm_top (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire ebpwm_pkg::ebpwm_apb_req_t apb_req,
    output      ebpwm_pkg::ebpwm_apb_rsp_t apb_rsp,
    input  wire logic                adc_enable,
    output      logic [3:0]          pwm_out,
    output      logic [3:0]          pwm_own_n,
    output      logic                adc_start
);
    import ebpwm_pkg::*;

    ebpwm_state_t s_reg;    // All state
    ebpwm_state_t s_next;   // Next state
    logic         pwm_mode; // Mode field selects PWM
    logic         access;   // APB access sampled this edge
    logic         wr;       // Write takes effect
    logic         hit;      // Address is mapped
    logic [31:0]  rd_val;   // Read mux result
    logic [3:0]   ps_lim;   // Prescale limit
    logic         tick;     // Prescaled Tosc tick
    logic         bound;    // Period boundary
    logic         db_done;  // Dead band elapsed
    logic [3:0]   act;      // Logical active per pin
    logic [3:0]   own;      // Pin owned by this block
    logic [3:0]   lvl;      // Pin level after polarity
    logic [3:0]   inact;    // Inactive level per pin
    logic [9:0]   db_len;   // Dead band length in clocks
    logic         evt_hit;  // Compare match this cycle
    logic         wrap_hit; // Timebase wrap that sets overflow

    // Registered outputs
    assign apb_rsp   = s_reg.rsp;
    assign pwm_out   = s_reg.out;
    assign pwm_own_n = s_reg.own_n;
    assign adc_start = s_reg.trig;

    assign pwm_mode = (s_reg.ctrl[MODE_HI -: 2] == MODE_PWM_TOP);

    // Bus decode; the write lands at the edge pready is seen
    // One wait state keeps the read mux off the output path
    assign access = apb_req.psel && apb_req.penable;
    assign wr     = access && apb_req.pwrite && s_reg.rsp.pready;

    // Limitation: only 1, 4 and 16 are offered
    // Prescale select: 1, 4 or 16
    always_comb begin
        case (s_reg.tcfg[TCFG_PS_HI -: 2])
            2'h0:    ps_lim = PS1_LIM;
            2'h1:    ps_lim = PS4_LIM;
            default: ps_lim = PS16_LIM;
        endcase
    end

    // Tick also paces the fine count of the duty compare
    // tick every prescale count of Tosc
    assign tick = s_reg.tcfg[TCFG_T2ON] && (s_reg.ps_cnt == ps_lim);
    // Trade-off: period register is compared live, not shadowed
    // last quarter of the period timer match
    assign bound = tick && (s_reg.q == 2'h3) && (s_reg.tmr == s_reg.per);

    // dead band length, 4 Tosc per count
    assign db_len  = 10'(s_reg.del_wk) * 10'(DB_CYC);
    // Counter saturates, so a long steady level never re-arms
    assign db_done = (s_reg.dbc >= db_len);

    // Longest dead band must fit the saturating counter
    if (255 * DB_CYC > int'(DBC_MAX)) begin : g_db_fit
        $error("dead band count exceeds its counter");
    end

    // Compare match and timebase wrap, shared with the flag clears
    assign evt_hit  = s_reg.tcfg[TCFG_T1ON] &&
                      (s_reg.ctrl[MODE_HI:MODE_LO] == MODE_SPECIAL) &&
                      (s_reg.tb == {s_reg.dutyh, s_reg.dutyl});
    assign wrap_hit = s_reg.tcfg[TCFG_T1ON] && (s_reg.tb == 16'hffff) && !evt_hit;

    // Per-configuration active pattern
    // Pattern is logical here: 1 means active
    always_comb begin
        act = 4'h0;
        own = 4'h0;
        case (s_reg.cfg_sh)
            CFG_SINGLE: begin
                act = {3'h0, s_reg.raw};
                own = 4'h1;
            end
            CFG_FWD: begin
                act = {s_reg.raw, 2'h0, 1'b1};
                own = 4'hf;
            end
            CFG_HALF: begin
                // Both legs wait, so neither turns on into the other
                // activation waits the dead band
                act = {2'h0, ~s_reg.raw & db_done, s_reg.raw & db_done};
                own = 4'h3;
            end
            CFG_REV: begin
                act = {1'b0, 1'b1, s_reg.raw, 1'b0};
                own = 4'hf;
            end
            default: begin
                act = 4'h0;
                own = 4'h0;
            end
        endcase
    end

    // Polarity per pin; A,C use bit 1, B,D bit 0
    for (genvar i = 0; i < 4; i++) begin : g_pin
        assign inact[i] = (i % 2 == 0) ? s_reg.pol_sh[1] : s_reg.pol_sh[0];
        assign lvl[i]   = act[i] ^ inact[i];
    end

    // Register read mux; unmapped reads return zero
    // Reads have no side effect; flags clear by writing one
    always_comb begin
        rd_val = 32'h0;
        hit    = 1'b1;
        case (apb_req.paddr)
            ADDR_CTRL:  rd_val[7:0]  = s_reg.ctrl;
            ADDR_DUTYL: rd_val[7:0]  = s_reg.dutyl;
            ADDR_DUTYH: rd_val[7:0]  = s_reg.dutyh;
            ADDR_DEL:   rd_val[7:0]  = s_reg.del;
            ADDR_PER:   rd_val[7:0]  = s_reg.per;
            ADDR_TCFG:  rd_val[3:0]  = s_reg.tcfg;
            ADDR_STAT: begin
                rd_val[STAT_EVT]  = s_reg.evt;
                rd_val[STAT_T1OV] = s_reg.t1ov;
                rd_val[STAT_T2IF] = s_reg.t2if;
                rd_val[STAT_TMR_LO +: 8] = s_reg.tmr;
            end
            ADDR_TB:    rd_val[15:0] = s_reg.tb;
            default:    hit = 1'b0;
        endcase
    end

    // Next-state logic for the whole block
    always_comb begin
        s_next = s_reg;

        // Slave answers one cycle into the access phase
        s_next.rsp.pready  = access && !s_reg.rsp.pready;
        s_next.rsp.pslverr = access && !s_reg.rsp.pready && !hit;
        // Data stands only with pready; the hold cycle reads zero
        s_next.rsp.prdata  = (access && !apb_req.pwrite && !s_reg.rsp.pready) ?
                             rd_val : 32'h0;

        // Converter enable pin, two-flop synchroniser
        s_next.adc_s1 = adc_enable;
        s_next.adc_s2 = s_reg.adc_s1;
        // Trigger is a one-cycle pulse
        s_next.trig   = 1'b0;

        // Prescaler and quarter-cycle phase
        // Prescale count holds while the period timer is off
        if (s_reg.tcfg[TCFG_T2ON]) begin
            s_next.ps_cnt = tick ? 4'h0 : s_reg.ps_cnt + 4'h1;
        end
        if (tick) begin
            s_next.q = s_reg.q + 2'h1;
            if (s_reg.q == 2'h3) begin
                s_next.tmr = bound ? 8'h0 : s_reg.tmr + 8'h1;
            end
        end

        // Period boundary: shadows load, flag sets
        if (bound) begin
            // Boundary flag marks a completed period
            s_next.t2if = 1'b1;
            s_next.cfg_sh  = s_reg.ctrl[CFG_HI:CFG_LO];
            s_next.pol_sh  = s_reg.ctrl[1:0];
            // duty from low register and bits 5:4
            s_next.duty_sh = {s_reg.dutyl, s_reg.ctrl[DLSB_HI:DLSB_LO]};
            // start only at a timer reset
            s_next.run     = pwm_mode;
        end

        // Duty at or above the period gives a steady level
        // active while fine count below duty
        s_next.raw = s_reg.run && ({s_reg.tmr, s_reg.q} < s_reg.duty_sh);

        // Dead band counter restarts on each raw edge
        // Counted in clocks, not prescaled ticks
        if (s_next.raw != s_reg.raw) begin
            s_next.dbc = 10'h0;
        end else if (s_reg.dbc != DBC_MAX) begin
            s_next.dbc = s_reg.dbc + 10'h1;
        end
        // delay copy loads at each boundary and at each falling raw edge
        if (bound || (s_reg.raw && !s_next.raw)) begin
            s_next.del_wk = s_reg.del;
        end

        // Pins; released pins rest at inactive level
        // Registered so no decode glitch reaches a switch
        for (int k = 0; k < 4; k++) begin
            s_next.out[k]   = (s_reg.run && own[k]) ? lvl[k] : inact[k];
            s_next.own_n[k] = !(s_reg.run && own[k]);
        end

        // Compare timebase; wrap sets its own flag
        // Timebase runs every clock, with no prescaler
        if (s_reg.tcfg[TCFG_T1ON]) begin
            s_next.tb = s_reg.tb + 16'h1;
            if (s_reg.tb == 16'hffff) begin
                s_next.t1ov = 1'b1;
            end
            // match sets flag and resets timebase
            if (s_reg.ctrl[MODE_HI:MODE_LO] == MODE_SPECIAL &&
                s_reg.tb == {s_reg.dutyh, s_reg.dutyl}) begin
                s_next.evt = 1'b1;
                s_next.tb  = 16'h0;
                s_next.t1ov = s_reg.t1ov;
                s_next.trig = s_reg.adc_s2;
            end
        end

        // Register writes at the sampled access edge
        if (wr) begin
            case (apb_req.paddr)
                ADDR_CTRL:  s_next.ctrl  = apb_req.pwdata[7:0];
                ADDR_DUTYL: s_next.dutyl = apb_req.pwdata[7:0];
                ADDR_DUTYH: s_next.dutyh = apb_req.pwdata[7:0];
                ADDR_DEL:   s_next.del   = apb_req.pwdata[7:0];
                ADDR_PER:   s_next.per   = apb_req.pwdata[7:0];
                ADDR_TCFG:  s_next.tcfg  = apb_req.pwdata[3:0];
                ADDR_TB:    s_next.tb    = apb_req.pwdata[15:0];
                // Write one clears; a same-cycle set wins
                ADDR_STAT: begin
                    if (apb_req.pwdata[STAT_EVT]) begin
                        s_next.evt = evt_hit;
                    end
                    if (apb_req.pwdata[STAT_T1OV]) begin
                        s_next.t1ov = wrap_hit;
                    end
                    if (apb_req.pwdata[STAT_T2IF]) begin
                        s_next.t2if = bound;
                    end
                end
                // Unmapped words drop the write
                default: ;
            endcase
        end

        // Mode off clears run at once; the period timer keeps counting
        // Shadows still reload at each period boundary while off
        if (s_reg.ctrl[MODE_HI:MODE_LO] == MODE_OFF) begin
            s_next.run = 1'b0;
        end
    end

    // State register; every field takes a constant on reset
    // Pins rest released until the first boundary
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg         <= '0;
            s_reg.ctrl    <= CTRL_RST;
            s_reg.del     <= DEL_RST;
            s_reg.per     <= PER_RST;
            s_reg.tcfg    <= TCFG_RST;
            s_reg.own_n   <= 4'hf;
        end else begin
            s_reg <= s_next;
        end
    end

endmodule : ebpwm_top

// File: verification/ebpwm_top_properties.sv
`timescale 1ns/1ps
// Port-level checks for the bridge PWM block
module ebpwm_top_properties (
    input wire logic                 pclk,
    input wire logic                 presetn,
    input ebpwm_pkg::ebpwm_apb_req_t apb_req,
    input ebpwm_pkg::ebpwm_apb_rsp_t apb_rsp,
    input wire logic                 adc_enable,
    input wire logic [3:0]           pwm_out,
    input wire logic [3:0]           pwm_own_n,
    input wire logic                 adc_start
);
    import ebpwm_pkg::*;
    // Single domain, reset mutes every check
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // First cycle of an access phase
    sequence s_access;
        $rose(apb_req.penable) && apb_req.psel;
    endsequence
    // One wait state, then the answer
    sequence s_answer;
        !apb_rsp.pready ##1 apb_rsp.pready;
    endsequence
    AST_ACCESS_WAIT: assert property (s_access |-> s_answer)
        else $error("access phase length wrong");
    AST_READY_PULSE: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("ready held too long");
    AST_ERR_QUAL: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
        else $error("error without ready");
    AST_RDATA_IDLE: assert property (!apb_rsp.pready |-> apb_rsp.prdata == 32'h0)
        else $error("read data not idle");
    AST_OWN_PATTERN: assert property (pwm_own_n inside {4'hf, 4'he, 4'hc, 4'h0})
        else $error("pin ownership pattern illegal");
    // Full bridge: A and C always opposite, whatever the polarity
    AST_BRIDGE_AC: assert property (pwm_own_n == 4'h0 |-> pwm_out[0] != pwm_out[2])
        else $error("bridge legs A and C agree");
    // Margin covers the synchroniser and output register
    AST_ADC_GATED: assert property (!adc_enable [*6] |=> !adc_start)
        else $error("conversion start while converter off");
    AST_RESET_RELEASE: assert property ($rose(presetn) |-> pwm_own_n == 4'hf)
        else $error("pins owned right after reset");
endmodule : ebpwm_top_properties

bind ebpwm_top ebpwm_top_properties u_props (
    .pclk       (pclk),
    .presetn    (presetn),
    .apb_req    (apb_req),
    .apb_rsp    (apb_rsp),
    .adc_enable (adc_enable),
    .pwm_out    (pwm_out),
    .pwm_own_n  (pwm_own_n),
    .adc_start  (adc_start)
);

// File: verification/ebpwm_driver_model.sv
`timescale 1ns/1ps
// Switch driver inputs seen behind the port pins
module ebpwm_driver_model (
    input  wire logic [3:0] pwm_out,
    input  wire logic [3:0] pwm_own_n,
    input  wire logic [3:0] dir,
    output      logic [3:0] pins
);
    import ebpwm_pkg::*;
    // Pull-downs keep switches off while a pin floats
    // drive only with direction cleared
    assign pins = pwm_out & ~pwm_own_n & ~dir;
endmodule : ebpwm_driver_model

// File: verification/enhanced_bridge_pwm_test.sv
`timescale 1ns/1ps
module enhanced_bridge_pwm_test;
    import ebpwm_pkg::*;
    logic           pclk;
    logic           presetn;
    ebpwm_apb_req_t req;
    ebpwm_apb_rsp_t rsp;
    logic           adc_enable;
    logic [3:0]     pwm_out;
    logic [3:0]     pwm_own_n;
    logic           adc_start;
    logic [3:0]     dir;
    logic [3:0]     pins;
    logic [31:0]    rdat;
    logic           rerr;
    int             n_errors;
    int             tests_run;
    int             n_adc;
    int             cnt [4];
    // Reset table, last entry unmapped
    logic [7:0]     ra [5] = '{ADDR_CTRL, ADDR_DUTYL, ADDR_DEL, ADDR_PER, 8'h20};
    logic [7:0]     rv [5] = '{CTRL_RST, 8'h00, DEL_RST, PER_RST, 8'h00};

    ebpwm_top uut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .adc_enable(adc_enable), .pwm_out(pwm_out), .pwm_own_n(pwm_own_n),
        .adc_start(adc_start));
    ebpwm_driver_model u_drv (.pwm_out(pwm_out), .pwm_own_n(pwm_own_n), .dir(dir),
        .pins(pins));

    // 25 MHz clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // Count conversion starts
    always @(posedge pclk) begin
        if (adc_start === 1'b1) n_adc++;
    end

    // Verdict and end of run
    task automatic summarize;
        if (n_errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; waits for ready, however long
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        req.psel    <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite  <= wr;
        req.paddr   <= a;
        req.pwdata  <= wd;
        @(posedge pclk);
        req.penable <= 1'b1;
        do @(posedge pclk); while (rsp.pready !== 1'b1);
        rdat = rsp.prdata;
        rerr = rsp.pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    // Clear boundary flag, poll for the next one
    task automatic wait_bnd;
        apb(1'b1, ADDR_STAT, 32'h4);
        do apb(1'b0, ADDR_STAT, 32'h0); while (rdat[STAT_T2IF] !== 1'b1);
    endtask : wait_bnd

    // High cycles per pin; any whole-period window works
    task automatic measure(input int n);
        cnt = '{default: 0};
        repeat (n) begin
            @(negedge pclk);
            for (int k = 0; k < 4; k++) cnt[k] += pins[k];
        end
    endtask : measure

    // Expected high cycles of pin p over two periods
    function automatic int exp_hi(int p, int cfg, int pol, int dc, int tc, int db);
        int act;
        if ((cfg == 0 && p > 0) || (cfg == 2 && p > 1)) return 0;
        case (cfg)
            0: act = dc;
            1: act = (p == 0) ? tc : (p == 3) ? dc : 0;
            2: act = (p == 0) ? dc - db : tc - dc - db;
            default: act = (p == 2) ? tc : (p == 1) ? dc : 0;
        endcase
        if (act < 0) act = 0;
        // A and C follow polarity bit 1, B and D bit 0
        if (((pol >> (1 - p % 2)) & 1) == 1) act = tc - act;
        return 2 * act;
    endfunction : exp_hi

    initial begin
        int per, ps, f, t10, d10, del, cfg, pol, tc, dc;
        req = '0;
        adc_enable = 1'b0;
        dir = 4'hf;
        presetn = 1'b0;
        n_errors = 0;
        tests_run = 0;
        n_adc = 0;
        void'($urandom(32'h744c6c4d));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        chk(32'(pwm_own_n), 32'hf);
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, ra[i], 32'h0);
            chk(rdat, {24'h0, rv[i]});
            chk(32'(rerr), 32'(i == 4));
        end
        dir <= 4'h0;
        // Long period: nothing owned before first boundary
        apb(1'b1, ADDR_TCFG, 32'h4);
        apb(1'b1, ADDR_CTRL, 32'h0c);
        chk(32'(pwm_own_n), 32'hf);
        wait_bnd;
        chk(32'(pwm_own_n), 32'he);
        // Every config and polarity, random period, duty, prescale
        for (int i = 0; i < 8; i++) begin
            cfg = i % 4;
            pol = i / 2;
            per = $urandom % 8;
            ps = $urandom % 3;
            f = (ps == 0) ? 1 : (ps == 1) ? 4 : 16;
            t10 = 4 * (per + 1);
            d10 = (cfg == 2) ? 1 + $urandom % (t10 - 1) : $urandom % (t10 + 2);
            if (i == 0) d10 = 0;
            if (i == 6) d10 = 1;
            del = (i == 6) ? 40 : $urandom % 3;
            apb(1'b1, ADDR_TCFG, 32'h4);
            apb(1'b1, ADDR_PER, per);
            apb(1'b1, ADDR_DEL, del);
            apb(1'b1, ADDR_DUTYL, d10 >> 2);
            apb(1'b1, ADDR_CTRL, cfg * 64 + (d10 % 4) * 16 + 12 + pol);
            // Timer wraps at full rate before the slow prescale
            wait_bnd;
            apb(1'b1, ADDR_TCFG, 4 + ps);
            wait_bnd;
            wait_bnd;
            chk(32'(pwm_own_n), (cfg == 0) ? 32'he : (cfg == 2) ? 32'hc : 32'h0);
            tc = t10 * f;
            dc = ((d10 < t10) ? d10 : t10) * f;
            measure(2 * tc);
            for (int k = 0; k < 4; k++) chk(cnt[k], exp_hi(k, cfg, pol, dc, tc, 4 * del));
        end
        // Compare special event, converter on then off
        apb(1'b1, ADDR_CTRL, 32'h0b);
        apb(1'b1, ADDR_DUTYL, 32'h40);
        apb(1'b1, ADDR_DUTYH, 32'h0);
        apb(1'b1, ADDR_TB, 32'h0);
        apb(1'b1, ADDR_STAT, 32'h7);
        adc_enable <= 1'b1;
        apb(1'b1, ADDR_TCFG, 32'h8);
        n_adc = 0;
        repeat (150) @(posedge pclk);
        chk(32'(n_adc != 0), 32'h1);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk(32'(rdat[1:0]), 32'h1);
        apb(1'b0, ADDR_TB, 32'h0);
        chk(32'(rdat < 32'h41), 32'h1);
        adc_enable <= 1'b0;
        apb(1'b1, ADDR_STAT, 32'h1);
        n_adc = 0;
        repeat (150) @(posedge pclk);
        chk(32'(n_adc), 32'h0);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk(32'(rdat[0]), 32'h1);
        summarize;
    end

    // Watchdog against a hang
    initial begin
        repeat (60000) @(posedge pclk);
        n_errors++;
        summarize;
    end
endmodule : enhanced_bridge_pwm_test
